// ===== hdl/sascc_defs.svh
// How it works
// - Precision converter resolution 14, 12, 10 or 8 bits; fewer bits, fewer SAR steps.
// - Low-power converter resolution 12, 10, 8 or 6 bits; fewer bits, fewer steps.
// - Precision result sits in a 32-bit register, left or right aligned.
// - Low-power result sits in a 16-bit register, left or right aligned, coherent.
// - Precision converter selects among 20 channels, 17 pads plus three internal.
// - Low-power converter selects among 25 channels, 19 external plus six internal.
// - Precision converter has four injected slots, each with its own result register.
// - Precision converter picks single-ended or differential per channel.
// - Precision oversampler: ratio 2 to 1024, left or right shift, 32-bit result.
// - Low-power oversampler: ratio 2 to 256, right shift up to 8, 16-bit result.
// - Modes: single, scan, continuous and discontinuous subsets per trigger.
// - Start by software or edge trigger of chosen polarity, regular and injected apart.
// - Precision flags: ready, sampling, conversion, sequence, injected, three watchdogs, overrun.
// - Low-power flags sampling, conversion, sequence, watchdog, overrun; they can wake.
// - Three watchdogs compare against high and low limits with filtering of isolated hits.
// - Auto-delay holds new regular precision conversions while the result FIFO is full.
// - Wait mode holds new low-power conversions while the result FIFO is full.
// - Auto-off powers the analog block only while a conversion runs.
// - Autonomous mode powers on at trigger, converts, powers off, results go to DMA.
// - Regular results reach DMA through a FIFO; filter path gets gain and offset.
// - Conversion timing follows the kernel tick only, never the bus handshake.
// - Battery channel is seen through a divide-by-four bridge.
`ifndef SASCC_DEFS_SVH
`define SASCC_DEFS_SVH
`define SASCC_ADDR_W   7
`define SASCC_CSEL     6
`define SASCC_IDX_W    6
`define SASCC_ISR      6'h00
`define SASCC_IER      6'h01
`define SASCC_CR       6'h02
`define SASCC_CFG      6'h03
`define SASCC_SQR1     6'h04
`define SASCC_SQR2     6'h05
`define SASCC_DIF      6'h06
`define SASCC_JSQR     6'h07
`define SASCC_DR       6'h08
`define SASCC_JDR0     6'h09
`define SASCC_AWDT0    6'h0D
`define SASCC_AWDF     6'h10
`define SASCC_GOFS     6'h11
`define SASCC_SMPT     6'h12
`define SASCC_F_RDY    0
`define SASCC_F_EOSMP  1
`define SASCC_F_EOC    2
`define SASCC_F_EOS    3
`define SASCC_F_OVR    4
`define SASCC_F_JEOC   5
`define SASCC_F_JEOS   6
`define SASCC_F_AWD    7
`define SASCC_NFLG     10
`define SASCC_CR_EN    0
`define SASCC_CR_START 1
`define SASCC_CR_JST   2
`define SASCC_CR_STOP  3
`define SASCC_C_RES    1:0
`define SASCC_C_ALIGN  2
`define SASCC_C_CONT   3
`define SASCC_C_DISC   4
`define SASCC_C_DNUM   7:5
`define SASCC_C_TRG    9:8
`define SASCC_C_JTRG   11:10
`define SASCC_C_ADLY   12
`define SASCC_C_AOFF   13
`define SASCC_C_OVSE   14
`define SASCC_C_OVSR   18:15
`define SASCC_C_OVSS   22:19
`define SASCC_C_OVSL   23
`define SASCC_C_LEN    26:24
`define SASCC_C_AUTON  27
`define SASCC_JLEN     30:29
`define SASCC_SLOT     8
`define SASCC_CH_W     5
`define SASCC_SEQ_N    8
`define SASCC_JSEQ_N   4
`define SASCC_THR_LO   15:0
`define SASCC_THR_HI   31:16
`define SASCC_OFS      15:0
`define SASCC_GAIN     31:16
`define SASCC_GOFS_RST 32'h4000_0000
`define SASCC_AWDT_RST 32'hFFFF_0000
`define SASCC_GAIN_FR  14
`define SASCC_FLT_W    4
`define SASCC_SMP_W    8
`define SASCC_AMAXW    14
`endif

// ===== hdl/sascc_pkg.sv
`include "sascc_defs.svh"
package sascc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PWR  = 3'h1,
    ST_SMP  = 3'h2,
    ST_SAR  = 3'h3,
    ST_RES  = 3'h4
  } sascc_state_t;
  typedef struct packed {
    logic                     we;
    logic                     re;
    logic [`SASCC_IDX_W-1:0]  idx;
    logic [31:0]              wdata;
  } sascc_req_t;
  typedef struct packed {
    logic                     pwr_on;
    logic                     sample;
    logic [`SASCC_AMAXW-1:0]  dac;
    logic [`SASCC_CH_W-1:0]   chan;
    logic                     diff;
    logic                     bat_div_en;
  } sascc_aout_t;
  typedef struct packed {
    logic ready;
    logic cmp;
  } sascc_ain_t;
endpackage

// ===== hdl/sascc_top.sv
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sascc_defs.svh"

module sascc_conv
  import sascc_pkg::*;
#(
  parameter int W     = 14,
  parameter int NCH   = 20,
  parameter int INJ   = 1,
  parameter int DIFF  = 1,
  parameter int OVSX  = 10,
  parameter int SHMAX = 15,
  parameter int SHL   = 1,
  parameter int DW    = 32,
  parameter int FD    = 4,
  parameter int NWD   = 3,
  parameter int VBAT  = 19
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        tick,
  input  var  sascc_req_t  req,
  output logic [31:0]      rdata,
  input  wire logic        trig_r,
  input  wire logic        trig_j,
  input  var  sascc_ain_t  ain,
  output sascc_aout_t      aout,
  output logic             dma_valid,
  output logic [DW-1:0]    dma_data,
  input  wire logic        dma_ready,
  output logic             flt_valid,
  output logic [DW-1:0]    flt_data,
  output logic             irq
);
  localparam int AW  = W + OVSX;
  localparam int FAW = $clog2(FD);
  localparam int NF  = `SASCC_NFLG;
  localparam int CW  = `SASCC_CH_W;

  if (W > `SASCC_AMAXW || DW > 32 || AW > 48 || FD < 2 ||
      (FD & (FD - 1)) != 0 || NWD > 3 || NCH > 32 ||
      OVSX > 10 || SHMAX > 15) begin : g_bad
    $error("sascc_conv: unsupported parameters");
  end

  sascc_state_t     st_q, st_d;
  logic             en_q, en_d, run_q, run_d, jpend_q, jpend_d;
  logic             inj_q, inj_d, rdy_q, rdy_d, tr_q, tr_d, tj_q, tj_d;
  logic [31:0]      cfg_q, cfg_d, dif_q, dif_d, awdf_q, awdf_d;
  logic [31:0]      gofs_q, gofs_d;
  logic [NF-1:0]    isr_q, isr_d, ier_q, ier_d, ev;
  logic [CW-1:0]    seq_q [`SASCC_SEQ_N], seq_d [`SASCC_SEQ_N];
  logic [CW-1:0]    jseq_q [`SASCC_JSEQ_N], jseq_d [`SASCC_JSEQ_N];
  logic [1:0]       jlen_q, jlen_d, jidx_q, jidx_d;
  logic [`SASCC_SMP_W-1:0] smp_q, smp_d, cnt_q, cnt_d;
  logic [31:0]      awdt_q [NWD], awdt_d [NWD];
  logic [3:0]       wcnt_q [NWD], wcnt_d [NWD];
  logic [2:0]       idx_q, idx_d, dcnt_q, dcnt_d;
  logic [3:0]       bit_q, bit_d;
  logic [W-1:0]     dac_q, dac_d, raw;
  logic [CW-1:0]    chan_q, chan_d;
  logic [AW-1:0]    acc_q, acc_d, acc_n;
  logic [OVSX-1:0]  ovn_q, ovn_d;
  logic [DW-1:0]    jdr_q [`SASCC_JSEQ_N], jdr_d [`SASCC_JSEQ_N];
  logic [DW-1:0]    mem_q [FD], mem_d [FD];
  logic [FAW-1:0]   wp_q, wp_d, rp_q, rp_d;
  logic [FAW:0]     fc_q, fc_d;
  logic [DW-1:0]    flt_q, flt_d, val, outv;
  logic             fltv_q, fltv_d;
  logic             hw_r, hw_j, sw_r, sw_j, stop, full, push, pop;
  logic             produce, adly, aoff;
  logic [3:0]       lsb, sh, ovr;
  logic [OVSX:0]    lim;
  logic [47:0]      wide;
  logic [15:0]      r16;
  logic [DW+15:0]   prod;

  function automatic logic edge_hit(input logic n, input logic p,
                                    input logic [1:0] pol);
    edge_hit = (pol[0] & n & ~p) | (pol[1] & ~n & p);
  endfunction

  always_comb begin
    st_d = st_q;
    en_d = en_q;
    run_d = run_q;
    jpend_d = jpend_q;
    inj_d = inj_q;
    cfg_d = cfg_q;
    dif_d = dif_q;
    awdf_d = awdf_q;
    gofs_d = gofs_q;
    ier_d = ier_q;
    isr_d = isr_q;
    seq_d = seq_q;
    jseq_d = jseq_q;
    jlen_d = jlen_q;
    jidx_d = jidx_q;
    smp_d = smp_q;
    cnt_d = cnt_q;
    awdt_d = awdt_q;
    wcnt_d = wcnt_q;
    idx_d = idx_q;
    dcnt_d = dcnt_q;
    bit_d = bit_q;
    dac_d = dac_q;
    chan_d = chan_q;
    acc_d = acc_q;
    acc_n = acc_q;
    ovn_d = ovn_q;
    jdr_d = jdr_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    fc_d = fc_q;
    flt_d = flt_q;
    fltv_d = 1'b0;
    ev = '0;
    sw_r = 1'b0;
    sw_j = 1'b0;
    stop = 1'b0;
    push = 1'b0;
    produce = 1'b0;
    outv = '0;
    wide = '0;
    prod = '0;
    rdy_d = ain.ready;
    tr_d = trig_r;
    tj_d = trig_j;
    adly = cfg_q[`SASCC_C_ADLY];
    aoff = cfg_q[`SASCC_C_AOFF] | cfg_q[`SASCC_C_AUTON];
    lsb = {1'b0, cfg_q[`SASCC_C_RES], 1'b0};
    raw = dac_q >> lsb;
    r16 = 16'(raw);
    sh = (cfg_q[`SASCC_C_OVSS] > 4'(SHMAX)) ? 4'(SHMAX) : cfg_q[`SASCC_C_OVSS];
    ovr = (cfg_q[`SASCC_C_OVSR] > 4'(OVSX - 1)) ? 4'(OVSX - 1)
                                                 : cfg_q[`SASCC_C_OVSR];
    lim = ((OVSX + 1)'(1) << (ovr + 4'h1)) - (OVSX + 1)'(1);
    full = (fc_q == (FAW + 1)'(FD));
    if (cfg_q[`SASCC_C_ALIGN])
      val = DW'({dac_q, {(DW - W){1'b0}}});
    else
      val = DW'(raw);
    if (req.we) begin
      case (req.idx)
        `SASCC_ISR: isr_d = isr_q & ~req.wdata[NF-1:0];
        `SASCC_IER: ier_d = req.wdata[NF-1:0];
        `SASCC_CR: begin
          en_d = req.wdata[`SASCC_CR_EN];
          sw_r = req.wdata[`SASCC_CR_START];
          sw_j = req.wdata[`SASCC_CR_JST];
          stop = req.wdata[`SASCC_CR_STOP];
        end
        `SASCC_CFG: cfg_d = req.wdata;
        `SASCC_SQR1, `SASCC_SQR2: begin
          for (int k = 0; k < `SASCC_JSEQ_N; k++)
            seq_d[k + (req.idx[0] ? 0 : `SASCC_JSEQ_N)] =
              req.wdata[k*`SASCC_SLOT +: CW];
        end
        `SASCC_DIF: dif_d = req.wdata;
        `SASCC_JSQR: begin
          for (int k = 0; k < `SASCC_JSEQ_N; k++)
            jseq_d[k] = req.wdata[k*`SASCC_SLOT +: CW];
          jlen_d = req.wdata[`SASCC_JLEN];
        end
        `SASCC_AWDF: awdf_d = req.wdata;
        `SASCC_GOFS: gofs_d = req.wdata;
        `SASCC_SMPT: smp_d = req.wdata[`SASCC_SMP_W-1:0];
        default: begin
          for (int k = 0; k < NWD; k++)
            if (req.idx == `SASCC_AWDT0 + 6'(k))
              awdt_d[k] = req.wdata;
        end
      endcase
    end
    hw_r = edge_hit(trig_r, tr_q, cfg_q[`SASCC_C_TRG]);
    hw_j = edge_hit(trig_j, tj_q, cfg_q[`SASCC_C_JTRG]) & (INJ != 0);
    if (en_q && (sw_r || hw_r))
      run_d = 1'b1;
    if (en_q && (sw_j || hw_j) && INJ != 0)
      jpend_d = 1'b1;
    ev[`SASCC_F_RDY] = ain.ready & ~rdy_q;
    pop = (fc_q != '0) &&
          (dma_ready || (req.re && req.idx == `SASCC_DR));
    case (st_q)
      ST_IDLE: begin
        // A pending injected slot waits only for the channel boundary
        if (en_q && (jpend_q || (run_q && !(adly && full)))) begin
          inj_d = jpend_q;
          chan_d = jpend_q ? jseq_q[jidx_q] : seq_q[idx_q];
          // Slot codes past the last channel fall back to channel 0
          if (int'(chan_d) >= NCH)
            chan_d = '0;
          st_d = ST_PWR;
        end
      end
      ST_PWR: begin
        if (ain.ready) begin
          cnt_d = '0;
          st_d = ST_SMP;
        end
      end
      ST_SMP: begin
        if (tick) begin
          if (cnt_q == smp_q) begin
            ev[`SASCC_F_EOSMP] = 1'b1;
            dac_d = '0;
            dac_d[W-1] = 1'b1;
            bit_d = 4'(W - 1);
            st_d = ST_SAR;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      ST_SAR: begin
        if (tick) begin
          if (!ain.cmp)
            dac_d[bit_q] = 1'b0;
          if (bit_q == lsb) begin
            st_d = ST_RES;
          end else begin
            bit_d = bit_q - 1'b1;
            dac_d[bit_q - 1'b1] = 1'b1;
          end
        end
      end
      ST_RES: begin
        st_d = ST_IDLE;
        for (int k = 0; k < NWD; k++) begin
          if (r16 > awdt_q[k][`SASCC_THR_HI] ||
              r16 < awdt_q[k][`SASCC_THR_LO]) begin
            if (wcnt_q[k] >= awdf_q[k*`SASCC_FLT_W +: `SASCC_FLT_W])
              ev[`SASCC_F_AWD + k] = 1'b1;
            else
              wcnt_d[k] = wcnt_q[k] + 1'b1;
          end else begin
            wcnt_d[k] = '0;
          end
        end
        if (inj_q) begin
          jdr_d[jidx_q] = val;
          ev[`SASCC_F_JEOC] = 1'b1;
          if (jidx_q == jlen_q) begin
            jidx_d = '0;
            jpend_d = 1'b0;
            ev[`SASCC_F_JEOS] = 1'b1;
          end else begin
            jidx_d = jidx_q + 1'b1;
          end
        end else begin
          produce = 1'b1;
          outv = val;
          if (cfg_q[`SASCC_C_OVSE]) begin
            acc_n = acc_q + AW'(raw);
            if (ovn_q == lim[OVSX-1:0]) begin
              wide = 48'(acc_n);
              wide = (SHL != 0 && cfg_q[`SASCC_C_OVSL]) ? wide << sh
                                                         : wide >> sh;
              outv = wide[DW-1:0];
              acc_d = '0;
              ovn_d = '0;
            end else begin
              produce = 1'b0;
              acc_d = acc_n;
              ovn_d = ovn_q + 1'b1;
            end
          end
        end
        if (produce) begin
          push = 1'b1;
          ev[`SASCC_F_EOC] = 1'b1;
          if (INJ != 0) begin
            prod = outv * gofs_q[`SASCC_GAIN];
            flt_d = prod[DW+`SASCC_GAIN_FR-1:`SASCC_GAIN_FR] -
                    DW'(gofs_q[`SASCC_OFS]);
            fltv_d = 1'b1;
          end
          if (idx_q == cfg_q[`SASCC_C_LEN]) begin
            ev[`SASCC_F_EOS] = 1'b1;
            idx_d = '0;
            dcnt_d = '0;
            run_d = cfg_q[`SASCC_C_CONT] & ~cfg_q[`SASCC_C_DISC];
          end else begin
            idx_d = idx_q + 1'b1;
            if (cfg_q[`SASCC_C_DISC]) begin
              if (dcnt_q == cfg_q[`SASCC_C_DNUM]) begin
                dcnt_d = '0;
                run_d = 1'b0;
              end else begin
                dcnt_d = dcnt_q + 1'b1;
              end
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (push && full && !pop) begin
      // New result dropped; the older unread ones are kept
      ev[`SASCC_F_OVR] = ~adly;
    end else if (push) begin
      mem_d[wp_q] = outv;
      wp_d = wp_q + 1'b1;
    end
    if (pop)
      rp_d = rp_q + 1'b1;
    fc_d = fc_q + (FAW + 1)'(push && !(full && !pop)) - (FAW + 1)'(pop);
    if (stop || !en_d) begin
      run_d = 1'b0;
      jpend_d = 1'b0;
    end
    if (!en_q)
      st_d = ST_IDLE;
    isr_d = isr_d | ev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      {en_q, run_q, jpend_q, inj_q, rdy_q, tr_q, tj_q} <= 7'h00;
      {cfg_q, dif_q, awdf_q} <= {3{32'h0000_0000}};
      gofs_q <= `SASCC_GOFS_RST;
      isr_q <= '0;
      ier_q <= '0;
      for (int k = 0; k < `SASCC_SEQ_N; k++)
        seq_q[k] <= '0;
      for (int k = 0; k < `SASCC_JSEQ_N; k++) begin
        jseq_q[k] <= '0;
        jdr_q[k] <= '0;
      end
      for (int k = 0; k < NWD; k++) begin
        awdt_q[k] <= `SASCC_AWDT_RST;
        wcnt_q[k] <= '0;
      end
      for (int k = 0; k < FD; k++)
        mem_q[k] <= '0;
      {jlen_q, jidx_q, idx_q, dcnt_q, bit_q} <= '0;
      {smp_q, cnt_q, dac_q, chan_q, acc_q, ovn_q} <= '0;
      {wp_q, rp_q, fc_q, flt_q, fltv_q} <= '0;
    end else begin
      st_q <= st_d;
      {en_q, run_q, jpend_q, inj_q} <= {en_d, run_d, jpend_d, inj_d};
      {rdy_q, tr_q, tj_q} <= {rdy_d, tr_d, tj_d};
      {cfg_q, dif_q, awdf_q, gofs_q} <= {cfg_d, dif_d, awdf_d, gofs_d};
      isr_q <= isr_d;
      ier_q <= ier_d;
      seq_q <= seq_d;
      jseq_q <= jseq_d;
      jdr_q <= jdr_d;
      awdt_q <= awdt_d;
      wcnt_q <= wcnt_d;
      mem_q <= mem_d;
      {jlen_q, jidx_q, idx_q, dcnt_q, bit_q} <=
        {jlen_d, jidx_d, idx_d, dcnt_d, bit_d};
      {smp_q, cnt_q, dac_q, chan_q, acc_q, ovn_q} <=
        {smp_d, cnt_d, dac_d, chan_d, acc_d, ovn_d};
      {wp_q, rp_q, fc_q, flt_q, fltv_q} <= {wp_d, rp_d, fc_d, flt_d, fltv_d};
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (req.idx)
      `SASCC_ISR: rdata = 32'(isr_q);
      `SASCC_IER: rdata = 32'(ier_q);
      `SASCC_CR: rdata = {28'h000_0000, 1'b0, jpend_q, run_q, en_q};
      `SASCC_CFG: rdata = cfg_q;
      `SASCC_SQR1, `SASCC_SQR2: begin
        for (int k = 0; k < `SASCC_JSEQ_N; k++)
          rdata[k*`SASCC_SLOT +: CW] =
            seq_q[k + (req.idx[0] ? 0 : `SASCC_JSEQ_N)];
      end
      `SASCC_DIF: rdata = dif_q;
      `SASCC_JSQR: begin
        for (int k = 0; k < `SASCC_JSEQ_N; k++)
          rdata[k*`SASCC_SLOT +: CW] = jseq_q[k];
        rdata[`SASCC_JLEN] = jlen_q;
      end
      `SASCC_DR: rdata = 32'(mem_q[rp_q]);
      `SASCC_AWDF: rdata = awdf_q;
      `SASCC_GOFS: rdata = gofs_q;
      `SASCC_SMPT: rdata = 32'(smp_q);
      default: begin
        for (int k = 0; k < `SASCC_JSEQ_N; k++)
          if (req.idx == `SASCC_JDR0 + 6'(k))
            rdata = 32'(jdr_q[k]);
        for (int k = 0; k < NWD; k++)
          if (req.idx == `SASCC_AWDT0 + 6'(k))
            rdata = awdt_q[k];
      end
    endcase
  end

  always_comb begin
    // Auto-off keeps the analog block dark between conversions
    aout.pwr_on = en_q & (~aoff | (st_q != ST_IDLE));
    aout.sample = (st_q == ST_SMP);
    aout.dac = `SASCC_AMAXW'(dac_q);
    aout.chan = chan_q;
    aout.diff = (DIFF != 0) & dif_q[chan_q];
    aout.bat_div_en = aout.pwr_on & (chan_q == CW'(VBAT));
  end

  assign dma_valid = (fc_q != '0);
  assign dma_data = mem_q[rp_q];
  assign flt_valid = fltv_q;
  assign flt_data = flt_q;
  assign irq = |(isr_q & ier_q);

endmodule // sascc_conv

module sascc_top
  import sascc_pkg::*;
#(
  parameter int KDIV = 2,
  parameter int FD   = 4
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [`SASCC_ADDR_W-1:0] avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     pc_trig_reg,
  input  wire logic                     pc_trig_inj,
  input  wire logic                     lp_trig,
  input  var  sascc_ain_t               pc_ain,
  output sascc_aout_t                   pc_aout,
  input  var  sascc_ain_t               lp_ain,
  output sascc_aout_t                   lp_aout,
  output logic                          pc_dma_valid,
  output logic [31:0]                   pc_dma_data,
  input  wire logic                     pc_dma_ready,
  output logic                          lp_dma_valid,
  output logic [15:0]                   lp_dma_data,
  input  wire logic                     lp_dma_ready,
  output logic                          flt_valid,
  output logic [31:0]                   flt_data,
  output logic                          pc_irq,
  output logic                          lp_irq
);
  if (KDIV < 1 || KDIV > 256) begin : g_bad
    $error("sascc_top: KDIV out of range");
  end

  logic        ack_q, ack_d, tick;
  logic [31:0] rd_q, rd_d, pc_rdata, lp_rdata;
  logic [7:0]  kc_q, kc_d;
  logic        lp_sel;
  sascc_req_t  pc_req, lp_req;

  // Kernel tick is free-running, so bus stalls never stretch a conversion
  assign tick = (kc_q == 8'h00);
  assign lp_sel = avs_address[`SASCC_CSEL];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rd_q;

  always_comb begin
    kc_d = (kc_q == 8'(KDIV - 1)) ? 8'h00 : kc_q + 8'h01;
    ack_d = (avs_read | avs_write) & ~ack_q;
    rd_d = rd_q;
    if (avs_read && !ack_q)
      rd_d = lp_sel ? lp_rdata : pc_rdata;
    pc_req.idx = avs_address[`SASCC_IDX_W-1:0];
    pc_req.wdata = avs_writedata;
    pc_req.we = avs_write & ack_q & ~lp_sel;
    pc_req.re = avs_read & ~ack_q & ~lp_sel;
    lp_req = pc_req;
    lp_req.we = avs_write & ack_q & lp_sel;
    lp_req.re = avs_read & ~ack_q & lp_sel;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      kc_q <= 8'h00;
    end else begin
      ack_q <= ack_d;
      rd_q <= rd_d;
      kc_q <= kc_d;
    end
  end

  sascc_conv #(
    .W(14), .NCH(20), .INJ(1), .DIFF(1), .OVSX(10), .SHMAX(15),
    .SHL(1), .DW(32), .FD(FD), .NWD(3), .VBAT(19)
  ) u_precision_converter (
    .clk(clk), .nrst(nrst), .tick(tick), .req(pc_req),
    .rdata(pc_rdata), .trig_r(pc_trig_reg), .trig_j(pc_trig_inj),
    .ain(pc_ain), .aout(pc_aout), .dma_valid(pc_dma_valid),
    .dma_data(pc_dma_data), .dma_ready(pc_dma_ready),
    .flt_valid(flt_valid), .flt_data(flt_data), .irq(pc_irq)
  );

  sascc_conv #(
    .W(12), .NCH(25), .INJ(0), .DIFF(0), .OVSX(8), .SHMAX(8),
    .SHL(0), .DW(16), .FD(FD), .NWD(3), .VBAT(24)
  ) u_lowpower_converter (
    .clk(clk), .nrst(nrst), .tick(tick), .req(lp_req),
    .rdata(lp_rdata), .trig_r(lp_trig), .trig_j(1'b0),
    .ain(lp_ain), .aout(lp_aout), .dma_valid(lp_dma_valid),
    .dma_data(lp_dma_data), .dma_ready(lp_dma_ready),
    .flt_valid(), .flt_data(), .irq(lp_irq)
  );

endmodule // sascc_top
`default_nettype wire

// ===== sim/sascc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sascc_mon
  import sascc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input var  sascc_aout_t pc_aout,
  input var  sascc_aout_t lp_aout,
  input wire logic        pc_dma_valid,
  input wire logic [31:0] pc_dma_data,
  input wire logic        pc_dma_ready,
  input wire logic        flt_valid,
  input wire logic        pc_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_bus_wait: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait");
  chk_pc_chan: assert property (pc_aout.chan < 5'h14) else $error("pch");
  chk_lp_chan: assert property (lp_aout.chan < 5'h19) else $error("lch");
  chk_lp_diff: assert property (!lp_aout.diff) else $error("diff");
  chk_lp_dac: assert property (lp_aout.dac[13:12] == 2'h0)
    else $error("dac");
  chk_smp_pwr: assert property (lp_aout.sample |-> lp_aout.pwr_on)
    else $error("smp");
  chk_flt_one: assert property (flt_valid |=> !flt_valid)
    else $error("flt");
  // A software read of the result register pops the queue as well
  chk_dma_hold: assert property (pc_dma_valid && !pc_dma_ready &&
    !(avs_read && avs_waitrequest && avs_address == 7'h08) |=>
    pc_dma_valid && $stable(pc_dma_data)) else $error("dma");
  chk_bat_chan: assert property (lp_aout.bat_div_en |->
    lp_aout.chan == 5'h18) else $error("bat");
  cov_pop: cover property (pc_dma_valid && pc_dma_ready);
  cov_irq: cover property ($rose(pc_irq));
  cov_flt: cover property (flt_valid);
endmodule // sascc_mon
bind sascc_top sascc_mon u_mon (.clk(clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .pc_aout(pc_aout), .lp_aout(lp_aout), .pc_dma_valid(pc_dma_valid),
  .pc_dma_data(pc_dma_data), .pc_dma_ready(pc_dma_ready),
  .flt_valid(flt_valid), .pc_irq(pc_irq));
`default_nettype wire

// ===== sim/sascc_acore.sv
`timescale 1ns/1ps
`default_nettype none
module sascc_acore
  import sascc_pkg::*;
#(
  parameter logic [13:0] VAL = 14'h0000
) (
  input  wire logic        clk,
  input  var  sascc_aout_t aout,
  output sascc_ain_t       ain
);
  logic [1:0] up_q = 2'h0;
  logic       tgl_q = 1'b0;
  always @(posedge clk) begin
    up_q  <= aout.pwr_on ? {up_q[0], 1'b1} : 2'h0;
    tgl_q <= ~tgl_q;
  end
  assign ain.ready = up_q[1];
  // Unpowered comparator gives junk, so a stale level cannot pass
  assign ain.cmp = ain.ready ? (VAL >= aout.dac) : tgl_q;
endmodule // sascc_acore
`default_nettype wire

// ===== sim/sar_adc_sequencer_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_control_tb;
  import sascc_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  rdy = 2'h0;
  logic [2:0]  trg = 3'h0;
  logic [31:0] fl = 32'h0;
  logic [6:0]  adr = 7'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q, e, pc_dd, flt_d;
  logic [15:0] lp_dd;
  logic        wt, pc_irq, lp_irq, pc_dv, lp_dv, flt_v;
  sascc_ain_t  pc_ain, lp_ain;
  sascc_aout_t pc_aout, lp_aout;
  int          err_count = 0;
  int          samples_checked = 0;
  always #5 clk = ~clk;
  // Filter output stands one cycle only, so keep the last word
  always @(posedge clk) begin
    if (flt_v)
      fl <= flt_d;
  end
  sascc_top #(.KDIV(1), .FD(4)) uut (.clk(clk), .nrst(nrst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .pc_trig_reg(trg[0]),
    .pc_trig_inj(trg[1]), .lp_trig(trg[2]), .pc_ain(pc_ain), .pc_aout(pc_aout),
    .lp_ain(lp_ain), .lp_aout(lp_aout), .pc_dma_valid(pc_dv),
    .pc_dma_data(pc_dd), .pc_dma_ready(rdy[0]), .lp_dma_valid(lp_dv),
    .lp_dma_data(lp_dd), .lp_dma_ready(rdy[1]), .flt_valid(flt_v),
    .flt_data(flt_d), .pc_irq(pc_irq), .lp_irq(lp_irq));
  sascc_acore #(.VAL(14'h1234)) u_pc (.clk(clk), .aout(pc_aout),
    .ain(pc_ain));
  sascc_acore #(.VAL(14'h0ABC)) u_lp (.clk(clk), .aout(lp_aout),
    .ain(lp_ain));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; data taken there
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    @(posedge clk);
    while (wt !== 1'b0)
      @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic conv(input logic b);
    bus(1'b1, {b, 6'h00}, 32'h8);
    bus(1'b1, {b, 6'h02}, 32'h3);
    q = 32'h0;
    while (q[3] !== 1'b1)
      bus(1'b0, {b, 6'h00}, 32'h0);
  endtask
  task automatic drain(input logic b);
    chk(b ? {16'h0, lp_dd} : pc_dd, e);
    rdy[b] <= 1'b1;
    @(posedge clk);
    rdy[b] <= 1'b0;
    repeat (3) begin
      bus(1'b0, {b, 6'h08}, 32'h0);
      chk(q, e);
    end
    chk({31'h0, b ? lp_dv : pc_dv}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, 7'h11, 32'h0);
    chk(q, 32'h4000_0000);
    bus(1'b0, 7'h0D, 32'h0);
    chk(q, 32'hFFFF_0000);
    bus(1'b0, 7'h3F, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 7'h02, 32'h1);
    bus(1'b1, 7'h42, 32'h1);
    bus(1'b1, 7'h01, 32'h4);
    conv(1'b0);
    chk({31'h0, pc_irq}, 32'h1);
    bus(1'b1, 7'h00, 32'h3FF);
    repeat (2) @(posedge clk);
    chk({31'h0, pc_irq}, 32'h0);
    bus(1'b0, 7'h08, 32'h0);
    chk(q, 32'h1234);
    for (int b = 0; b < 2; b++) begin
      e = b ? 32'h0ABC : 32'h1234;
      // A fifth result into a full queue must flag overrun
      repeat (5) conv(b[0]);
      chk(q & 32'h10, 32'h10);
      drain(b[0]);
      bus(1'b1, {b[0], 6'h00}, 32'h3FF);
      bus(1'b1, {b[0], 6'h03}, 32'h1000);
      repeat (4) conv(b[0]);
      bus(1'b1, {b[0], 6'h00}, 32'h3FF);
      bus(1'b1, {b[0], 6'h02}, 32'h3);
      repeat (100) @(posedge clk);
      bus(1'b0, {b[0], 6'h00}, 32'h0);
      chk(q & 32'h1C, 32'h0);
      bus(1'b1, {b[0], 6'h02}, 32'h9);
      drain(b[0]);
    end
    bus(1'b1, 7'h03, 32'h500);
    bus(1'b1, 7'h43, 32'h100);
    bus(1'b1, 7'h00, 32'h3FF);
    bus(1'b1, 7'h40, 32'h3FF);
    trg <= 3'h7;
    repeat (80) @(posedge clk);
    bus(1'b0, 7'h00, 32'h0);
    chk(q & 32'h48, 32'h48);
    bus(1'b0, 7'h09, 32'h0);
    chk(q, 32'h1234);
    bus(1'b0, 7'h08, 32'h0);
    chk(q, 32'h1234);
    bus(1'b0, 7'h48, 32'h0);
    chk(q, 32'h0ABC);
    chk(fl, 32'h1234);
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule // sar_adc_sequencer_control_tb
`default_nettype wire
